// ---- hw/srb_axil.v ----
/*
 axi4-lite slave front end, one write and one read in flight.
 assumes the owner decodes reg_raddr/reg_waddr combinationally.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srb_defines.vh"

module srb_axil (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   output wire        reg_wr,
   output reg  [7:0]  reg_waddr,
   output reg  [31:0] reg_wdata,
   output reg  [3:0]  reg_wstrb,
   input  wire        reg_werr,
   output wire [7:0]  reg_raddr,
   input  wire [31:0] reg_rdata,
   input  wire        reg_rerr
);

   reg aw_hold_r;
   reg w_hold_r;

   assign awready   = ~aw_hold_r & ~bvalid;
   assign wready    = ~w_hold_r & ~bvalid;
   assign reg_wr    = aw_hold_r & w_hold_r & ~bvalid;
   assign arready   = ~rvalid;
   assign reg_raddr = araddr;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         reg_waddr <= 8'h00;
         reg_wdata <= 32'h00000000;
         reg_wstrb <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `SRB_RESP_OKAY;
      end
      else
      begin
         // address and data may come in either order
         if (awvalid && awready)
         begin
            aw_hold_r <= 1'b1;
            reg_waddr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_hold_r  <= 1'b1;
            reg_wdata <= wdata;
            reg_wstrb <= wstrb;
         end
         if (reg_wr)
         begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= reg_werr ? `SRB_RESP_SLVERR : `SRB_RESP_OKAY;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `SRB_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata  <= reg_rerr ? 32'h00000000 : reg_rdata;
         rresp  <= reg_rerr ? `SRB_RESP_SLVERR : `SRB_RESP_OKAY;
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end

endmodule

`default_nettype wire

// ---- hw/srb_defines.vh ----
/*
 constants for the read-burst block: register offsets, field positions,
 reset values and burst timing counts. assumes it is included by bare name.
*/
`ifndef SRB_DEFINES_VH
`define SRB_DEFINES_VH

`define SRB_CTRL_OFF      8'h00
`define SRB_LAT_OFF       8'h04
`define SRB_SEED_OFF      8'h08
`define SRB_STAT_OFF      8'h0C

`define SRB_CTRL_BL_LSB   0
`define SRB_CTRL_BL_MSB   1
`define SRB_CTRL_DLL_BIT  2
`define SRB_LAT_AL_LSB    0
`define SRB_LAT_AL_MSB    3
`define SRB_LAT_CL_LSB    4
`define SRB_LAT_CL_MSB    7

`define SRB_BL_RST        2'h0
`define SRB_DLL_RST       1'h0
`define SRB_AL_RST        4'h0
`define SRB_CL_RST        4'h5
`define SRB_SEED_RST      16'h0000

`define SRB_BL_FIXED8     2'h0
`define SRB_BL_OTF        2'h1
`define SRB_BL_FIXED4     2'h2

`define SRB_STAT_LOCK_BIT 0
`define SRB_STAT_BUSY_BIT 1
`define SRB_STAT_CHOP_BIT 2
`define SRB_STAT_AP_BIT   3
`define SRB_STAT_RCNT_LSB 8
`define SRB_STAT_DROP_LSB 16

`define SRB_COMMAND_TO_COMMAND_SPACING_CK       4
`define SRB_LAST_BL8      3'h7
`define SRB_LAST_BC4      3'h3
`define SRB_DLL_LOCK_CK   8'h10
`define SRB_QDEPTH        3'h4

`define SRB_RESP_OKAY     2'h0
`define SRB_RESP_SLVERR   2'h2

`endif

// ---- hw/srb_sync.v ----
/*
 two flip-flop synchroniser for a vector of pins.
 assumes each bit is an independent level from outside the aclk domain.
*/
`timescale 1ns/100ps
`default_nettype none

module srb_sync #(
   parameter W = 1
) (
   input  wire         aclk,
   input  wire         aresetn,
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] pin_s_r
);

   reg [W-1:0] meta_r;

   // first stage feeds only the second
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_r  <= {W{1'b1}};
         pin_s_r <= {W{1'b1}};
      end
      else
      begin
         meta_r  <= pin_in;
         pin_s_r <= meta_r;
      end
   end

endmodule

`default_nettype wire

// ---- hw/srb_top.v ----
/*
 read-burst side of a ddr3 device: command capture on the memory clock,
 latency scheduling, ddr data and strobe drive, output release.
 assumes ck and command pins are much slower than aclk (5 mhz vs 40 mhz),
 registers reached over axi4-lite.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "srb_defines.vh"

module srb_top (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        ck,
   input  wire        cs_n,
   input  wire        ras_n,
   input  wire        cas_n,
   input  wire        we_n,
   input  wire [12:0] addr,
   output reg  [15:0] dq_o,
   output reg         dq_oe_n,
   output reg         dqs_o,
   output reg         dqs_n_o,
   output reg         dqs_oe_n
);

   localparam ST_IDLE = 2'h0;
   localparam ST_PRE  = 2'h1;
   localparam ST_DATA = 2'h2;

   // register bus
   wire        reg_wr;
   wire [7:0]  reg_waddr;
   wire [31:0] reg_wdata;
   wire [3:0]  reg_wstrb;
   wire [7:0]  reg_raddr;
   reg  [31:0] reg_rdata;

   // configuration and status
   reg  [1:0]  bl_mode_r;
   reg         dll_en_r;
   reg  [3:0]  al_r;
   reg  [3:0]  cl_r;
   reg  [15:0] seed_r;
   reg         locked_r;
   reg  [7:0]  lock_cnt_r;
   reg         last_chop_r;
   reg         last_ap_r;
   reg  [7:0]  rd_cnt_r;
   reg  [7:0]  drop_cnt_r;

   // link side
   wire [17:0] pins_s;
   reg         ck_d_r;
   reg  [7:0]  tick_r;
   reg  [7:0]  q_tick [0:3];
   reg         q_chop [0:3];
   reg  [9:0]  q_col  [0:3];
   reg  [1:0]  q_head_r;
   reg  [1:0]  q_tail_r;
   reg  [2:0]  q_cnt_r;
   reg  [1:0]  state_r;
   reg  [2:0]  beat_r;
   reg  [2:0]  last_r;
   reg         chop_r;
   reg  [9:0]  col_r;

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `SRB_CTRL_OFF) || (a == `SRB_LAT_OFF) ||
                  (a == `SRB_SEED_OFF) || (a == `SRB_STAT_OFF);
      end
   endfunction

   // sequential wrap inside the burst; chop wraps inside four
   function [15:0] beat_word;
      input [15:0] seed;
      input [9:0]  col;
      input [2:0]  beat;
      input        chop;
      reg   [2:0]  lo;
      begin
         lo = col[2:0] + beat;
         if (chop)
            lo = {col[2], lo[1:0]};
         beat_word = seed ^ {6'h00, col[9:3], lo};
      end
   endfunction

   srb_axil u_axil (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .awaddr    (s_axi_awaddr),
      .awvalid   (s_axi_awvalid),
      .awready   (s_axi_awready),
      .wdata     (s_axi_wdata),
      .wstrb     (s_axi_wstrb),
      .wvalid    (s_axi_wvalid),
      .wready    (s_axi_wready),
      .bresp     (s_axi_bresp),
      .bvalid    (s_axi_bvalid),
      .bready    (s_axi_bready),
      .araddr    (s_axi_araddr),
      .arvalid   (s_axi_arvalid),
      .arready   (s_axi_arready),
      .rdata     (s_axi_rdata),
      .rresp     (s_axi_rresp),
      .rvalid    (s_axi_rvalid),
      .rready    (s_axi_rready),
      .reg_wr    (reg_wr),
      .reg_waddr (reg_waddr),
      .reg_wdata (reg_wdata),
      .reg_wstrb (reg_wstrb),
      .reg_werr  (~mapped(reg_waddr)),
      .reg_raddr (reg_raddr),
      .reg_rdata (reg_rdata),
      .reg_rerr  (~mapped(reg_raddr))
   );

   // ck and command share one synchroniser so they stay aligned
   srb_sync #(
      .W (18)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  ({ck, cs_n, ras_n, cas_n, we_n, addr}),
      .pin_s_r (pins_s)
   );

   wire        ck_s    = pins_s[17];
   wire        ck_rise = ck_s & ~ck_d_r;
   wire        ck_fall = ~ck_s & ck_d_r;
   wire        rd_cmd  = ~pins_s[16] & pins_s[15] & ~pins_s[14] & pins_s[13];
   wire [12:0] addr_s  = pins_s[12:0];
   wire [7:0]  now     = tick_r + 8'h01;
   wire [7:0]  rl      = {4'h0, al_r} + {4'h0, cl_r};
   wire        q_full  = (q_cnt_r == `SRB_QDEPTH);
   wire        q_any   = (q_cnt_r != 3'h0);
   wire        do_push = ck_rise & rd_cmd & locked_r & ~q_full;
   wire        burst_on = (state_r == ST_DATA) && (beat_r != last_r);
   wire        start   = ck_rise & locked_r & ~burst_on & q_any &
                         (q_tick[q_head_r] == now);
   wire        pre     = ck_rise & locked_r & ~burst_on & q_any &
                         (q_tick[q_head_r] == now + 8'h01);

   // otf select bit only; fixed modes ignore it
   wire        cmd_chop = (bl_mode_r == `SRB_BL_FIXED4) ||
                          ((bl_mode_r == `SRB_BL_OTF) && !addr_s[12]);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bl_mode_r <= `SRB_BL_RST;
         dll_en_r  <= `SRB_DLL_RST;
         al_r      <= `SRB_AL_RST;
         cl_r      <= `SRB_CL_RST;
         seed_r    <= `SRB_SEED_RST;
      end
      else if (reg_wr)
      begin
         if (reg_waddr == `SRB_CTRL_OFF && reg_wstrb[0])
         begin
            bl_mode_r <= reg_wdata[`SRB_CTRL_BL_MSB:`SRB_CTRL_BL_LSB];
            dll_en_r  <= reg_wdata[`SRB_CTRL_DLL_BIT];
         end
         if (reg_waddr == `SRB_LAT_OFF && reg_wstrb[0])
         begin
            al_r <= reg_wdata[`SRB_LAT_AL_MSB:`SRB_LAT_AL_LSB];
            cl_r <= reg_wdata[`SRB_LAT_CL_MSB:`SRB_LAT_CL_LSB];
         end
         if (reg_waddr == `SRB_SEED_OFF)
         begin
            if (reg_wstrb[0])
               seed_r[7:0] <= reg_wdata[7:0];
            if (reg_wstrb[1])
               seed_r[15:8] <= reg_wdata[15:8];
         end
      end
   end

   always @*
   begin
      reg_rdata = 32'h00000000;
      case (reg_raddr)
         `SRB_CTRL_OFF:
            reg_rdata = {29'h00000000, dll_en_r, bl_mode_r};
         `SRB_LAT_OFF:
            reg_rdata = {24'h000000, cl_r, al_r};
         `SRB_SEED_OFF:
            reg_rdata = {16'h0000, seed_r};
         `SRB_STAT_OFF:
         begin
            reg_rdata[`SRB_STAT_LOCK_BIT] = locked_r;
            reg_rdata[`SRB_STAT_BUSY_BIT] = (state_r != ST_IDLE);
            reg_rdata[`SRB_STAT_CHOP_BIT] = last_chop_r;
            reg_rdata[`SRB_STAT_AP_BIT]   = last_ap_r;
            reg_rdata[`SRB_STAT_RCNT_LSB+7:`SRB_STAT_RCNT_LSB] = rd_cnt_r;
            reg_rdata[`SRB_STAT_DROP_LSB+7:`SRB_STAT_DROP_LSB] = drop_cnt_r;
         end
         default:
            reg_rdata = 32'h00000000;
      endcase
   end

   // lock time counted in link clocks; disable drops lock at once
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ck_d_r     <= 1'b1; // same level as synchroniser reset, no false edge
         tick_r     <= 8'h00;
         lock_cnt_r <= 8'h00;
         locked_r   <= 1'b0;
      end
      else
      begin
         ck_d_r <= ck_s;
         if (ck_rise)
            tick_r <= now;
         if (!dll_en_r)
         begin
            lock_cnt_r <= 8'h00;
            locked_r   <= 1'b0;
         end
         else if (ck_rise && !locked_r)
         begin
            lock_cnt_r <= lock_cnt_r + 8'h01;
            if (lock_cnt_r == `SRB_DLL_LOCK_CK - 8'h01)
               locked_r <= 1'b1;
         end
      end
   end

   // pending reads, stamped with the ck count of their first data edge
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q_head_r    <= 2'h0;
         q_tail_r    <= 2'h0;
         q_cnt_r     <= 3'h0;
         rd_cnt_r    <= 8'h00;
         drop_cnt_r  <= 8'h00;
         last_chop_r <= 1'b0;
         last_ap_r   <= 1'b0;
      end
      else if (!locked_r)
      begin
         q_head_r <= 2'h0;
         q_tail_r <= 2'h0;
         q_cnt_r  <= 3'h0;
         if (ck_rise && rd_cmd)
            drop_cnt_r <= drop_cnt_r + 8'h01;
      end
      else
      begin
         if (do_push)
         begin
            q_tick[q_tail_r] <= now + rl;
            q_chop[q_tail_r] <= cmd_chop;
            q_col[q_tail_r]  <= addr_s[9:0];
            q_tail_r         <= q_tail_r + 2'h1;
            rd_cnt_r         <= rd_cnt_r + 8'h01;
            last_chop_r      <= cmd_chop;
            last_ap_r        <= addr_s[10];
         end
         else if (ck_rise && rd_cmd)
            drop_cnt_r <= drop_cnt_r + 8'h01;
         if (start)
            q_head_r <= q_head_r + 2'h1;
         if (do_push && !start)
            q_cnt_r <= q_cnt_r + 3'h1;
         else if (start && !do_push)
            q_cnt_r <= q_cnt_r - 3'h1;
      end
   end

   // dq drives on both ck edges; strobe follows ck, so the low half
   // after the last falling beat is the postamble
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r  <= ST_IDLE;
         beat_r   <= 3'h0;
         last_r   <= `SRB_LAST_BL8;
         chop_r   <= 1'b0;
         col_r    <= 10'h000;
         dq_o     <= 16'h0000;
         dq_oe_n  <= 1'b1;
         dqs_o    <= 1'b0;
         dqs_n_o  <= 1'b1;
         dqs_oe_n <= 1'b1;
      end
      else if (ck_rise)
      begin
         case (state_r)
            ST_IDLE, ST_PRE, ST_DATA:
            begin
               if (burst_on && locked_r)
               begin
                  beat_r  <= beat_r + 3'h1;
                  dq_o    <= beat_word(seed_r, col_r, beat_r + 3'h1,
                                       chop_r);
                  dqs_o   <= 1'b1;
                  dqs_n_o <= 1'b0;
               end
               else if (start)
               begin
                  state_r  <= ST_DATA;
                  beat_r   <= 3'h0;
                  chop_r   <= q_chop[q_head_r];
                  col_r    <= q_col[q_head_r];
                  last_r   <= q_chop[q_head_r] ? `SRB_LAST_BC4 :
                                                  `SRB_LAST_BL8;
                  dq_o     <= beat_word(seed_r, q_col[q_head_r], 3'h0,
                                        q_chop[q_head_r]);
                  dq_oe_n  <= 1'b0;
                  dqs_o    <= 1'b1;
                  dqs_n_o  <= 1'b0;
                  dqs_oe_n <= 1'b0;
               end
               else if (pre)
               begin
                  state_r  <= ST_PRE;
                  dq_oe_n  <= 1'b1;
                  dqs_o    <= 1'b0;
                  dqs_n_o  <= 1'b1;
                  dqs_oe_n <= 1'b0;
               end
               else
               begin
                  // latency plus 4 or plus 2 lands here
                  state_r  <= ST_IDLE;
                  dq_oe_n  <= 1'b1;
                  dqs_oe_n <= 1'b1;
                  dqs_o    <= 1'b0;
                  dqs_n_o  <= 1'b1;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
      else if (ck_fall && state_r == ST_DATA && beat_r != last_r)
      begin
         beat_r  <= beat_r + 3'h1;
         dq_o    <= beat_word(seed_r, col_r, beat_r + 3'h1, chop_r);
         dqs_o   <= 1'b0;
         dqs_n_o <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// ---- tb/srb_chk_assertions.sv ----
/* pin and bus checker for srb_top, attached by bind.
   assumes one aclk domain with synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module srb_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [15:0] dq_o,
   input wire logic        dq_oe_n,
   input wire logic        dqs_o,
   input wire logic        dqs_n_o,
   input wire logic        dqs_oe_n
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [7:0] low_r;
   // drive window length in aclk cycles, 8 per memory clock
   always_ff @(posedge aclk)
      if (!aresetn || dq_oe_n)
         low_r <= 8'h00;
      else
         low_r <= low_r + 8'h01;
   property p_strobe_with_data;
      !dq_oe_n |-> !dqs_oe_n;
   endproperty
   a_strobe_with_data: assert property (p_strobe_with_data)
      else $error("data driven without strobe");
   property p_strobe_pair;
      !dqs_oe_n |-> dqs_n_o != dqs_o;
   endproperty
   a_strobe_pair: assert property (p_strobe_pair)
      else $error("strobe pair not complementary");
   property p_strobe_low_idle;
      !dqs_oe_n && dq_oe_n |-> !dqs_o;
   endproperty
   a_strobe_low_idle: assert property (p_strobe_low_idle)
      else $error("strobe high outside data window");
   property p_data_on_edge;
      !dq_oe_n && !$past(dq_oe_n) && $stable(dqs_o) |-> $stable(dq_o);
   endproperty
   a_data_on_edge: assert property (p_data_on_edge)
      else $error("data changed without strobe edge");
   property p_window_len;
      $rose(dq_oe_n) |-> low_r inside {8'h10, 8'h20, 8'h40};
   endproperty
   a_window_len: assert property (p_window_len)
      else $error("data window length wrong");
   property p_release_pair;
      $rose(dq_oe_n) |-> $rose(dqs_oe_n) || !dqs_o;
   endproperty
   a_release_pair: assert property (p_release_pair)
      else $error("strobe not released with data");
   property p_read_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer late");
   property p_write_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_write_done: assert property (p_write_done)
      else $error("write response held after taken");
endmodule
bind srb_top srb_chk i_srb_chk (
   .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .dq_o, .dq_oe_n,
   .dqs_o, .dqs_n_o, .dqs_oe_n
);
`default_nettype wire

// ---- tb/srb_ctrl_model.sv ----
/* memory controller model: free memory clock and command pins.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/100ps
`default_nettype none
module srb_ctrl_model #(
   parameter int ACTIVATE_TO_PRECHARGE_MINIMUM = 6,
   parameter int PRECHARGE_PERIOD  = 3
) (
   output logic        ck,
   output logic        cs_n,
   output logic        ras_n,
   output logic        cas_n,
   output logic        we_n,
   output logic [12:0] addr
);
   localparam int RTP = 4;
   int rises = 0;
   int cmd_rise = 0;
   initial
   begin
      ck = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      addr = 13'h1FFF;
   end
   // runs free: the device needs rises to lock
   always #100 ck = ~ck;
   always @(posedge ck)
      rises++;
   // next command lands gap rises later, gap of 2 at least
   task automatic cmd(input logic [3:0] c, input logic [12:0] a,
                      input int gap);
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} <= c;
      addr <= a;
      cmd_rise = rises + 1;
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} <= 4'hF;
      addr <= ~a; // released bus shows no stale value
      repeat (gap - 2) @(negedge ck);
   endtask
   // conservative: counts from now, not from the read
   task automatic pre(input int al);
      repeat ((al + RTP > ACTIVATE_TO_PRECHARGE_MINIMUM) ? al + RTP : ACTIVATE_TO_PRECHARGE_MINIMUM) @(negedge ck);
      cmd(4'h2, 13'h0400, PRECHARGE_PERIOD + 1);
   endtask
endmodule
`default_nettype wire

// ---- tb/srb_top_tb.sv ----
/* self-checking bench for srb_top: axi4-lite master tasks and a
   controller model on the memory side; checker comes in by bind. */
`timescale 1ns/100ps
`default_nettype none
`include "srb_defines.vh"
module srb_top_tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, ck, cs_n, ras_n, cas_n, we_n;
   logic        dq_oe_n, dqs_o, dqs_n_o, dqs_oe_n;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [12:0] addr;
   logic [15:0] dq_o;
   logic [15:0] seed_v = 16'h0;
   int          al_v = 0, cl_v = 5, fail_count = 0, checked = 0, rd_v = 0;
   srb_top i_srb_top (.*);
   srb_ctrl_model i_srb_ctrl_model (.*);
   always #12.5 aclk = ~aclk;
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic hang;
      chk("timeout", 1, 0);
      wrap_up();
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      if (n == 50)
         hang();
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, er);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      if (n == 50)
         hang();
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      chk("rresp", s_axi_rresp, er);
   endtask
   function automatic logic [15:0] pat(input logic [9:0] c, input int k,
                                       input int len);
      logic [2:0] lo;
      lo = c[2:0] + k[2:0];
      if (len == 4)
         lo = {c[2], lo[1:0]};
      return seed_v ^ {6'h00, c[9:3], lo};
   endfunction
   // one read, or two eights four cycles apart, and its data window
   task automatic run(input logic a12, input logic [9:0] col,
                      input int len, input logic two);
      int n, k, t_on;
      logic [15:0] w[$];
      logic [31:0] d;
      logic pq;
      i_srb_ctrl_model.cmd(4'h5, {a12, 1'b0, ~a12, col}, 4);
      n = i_srb_ctrl_model.cmd_rise;
      rd_v += two ? 2 : 1;
      if (two)
         i_srb_ctrl_model.cmd(4'h5, {a12, 1'b0, ~a12, col + 10'h008}, 2);
      for (k = 0; k < 2000 && dq_oe_n !== 1'b0; k++)
         @(posedge aclk);
      if (k == 2000)
         hang();
      t_on = i_srb_ctrl_model.rises;
      pq = 1'b0;
      for (k = 0; k < 2000 && dq_oe_n === 1'b0; k++)
      begin
         if (dqs_o !== pq)
            w.push_back(dq_o);
         pq = dqs_o;
         @(posedge aclk);
      end
      if (k == 2000)
         hang();
      chk("first", t_on, n + al_v + cl_v);
      chk("release", i_srb_ctrl_model.rises,
          n + al_v + cl_v + len / 2 + (two ? 4 : 0));
      chk("beats", w.size(), two ? 2 * len : len);
      foreach (w[i])
         chk("beat", w[i],
             pat(col + 10'(8 * (i / len)), i % len, len));
      axr(`SRB_STAT_OFF, d, `SRB_RESP_OKAY);
      chk("stat", {d[15:8], d[3:1]},
          {8'(rd_v), ~a12, len == 4, 1'b0});
      i_srb_ctrl_model.pre(al_v);
   endtask
   task automatic s_reset;
      logic [31:0] d;
      axr(`SRB_CTRL_OFF, d, `SRB_RESP_OKAY);
      chk("ctrl", d[2:0], 3'h0);
      axr(`SRB_LAT_OFF, d, `SRB_RESP_OKAY);
      chk("lat", d[7:0], 8'h50);
      axr(`SRB_SEED_OFF, d, `SRB_RESP_OKAY);
      chk("seed", d, 32'h0);
      axr(8'h10, d, `SRB_RESP_SLVERR);
      chk("hole", d, 32'h0);
      axw(8'h10, 32'h1, `SRB_RESP_SLVERR);
      axw(`SRB_STAT_OFF, 32'hFFFF_FFFF, `SRB_RESP_OKAY);
   endtask
   // unlocked reads are dropped, then the loop locks
   task automatic s_lock;
      logic [31:0] d;
      logic drv;
      drv = 1'b0;
      axw(`SRB_CTRL_OFF, 32'h1, `SRB_RESP_OKAY);
      i_srb_ctrl_model.cmd(4'h5, 13'h1000, 4);
      repeat (160)
      begin
         @(posedge aclk);
         drv = drv | (dq_oe_n !== 1'b1);
      end
      chk("drive", drv, 1'b0);
      axr(`SRB_STAT_OFF, d, `SRB_RESP_OKAY);
      chk("drop", {d[23:16], d[0]}, 9'h002);
      axw(`SRB_CTRL_OFF, 32'h5, `SRB_RESP_OKAY);
      repeat (20) @(posedge ck);
      axr(`SRB_STAT_OFF, d, `SRB_RESP_OKAY);
      chk("lock", d[0], 1'b1);
   endtask
   task automatic s_modes;
      int m, len;
      seed_v = 16'hA5C3;
      axw(`SRB_SEED_OFF, 32'h0000_A5C3, `SRB_RESP_OKAY);
      for (m = 0; m < 8; m++)
      begin
         axw(`SRB_CTRL_OFF, 32'(4 + m / 2), `SRB_RESP_OKAY);
         len = (m / 2 == 2 || m == 2) ? 4 : 8;
         run(m[0], 10'h1F5 + 10'(64 * m), len, 1'b0);
      end
   endtask
   task automatic s_lat;
      al_v = 4;
      axw(`SRB_LAT_OFF, 32'h54, `SRB_RESP_OKAY);
      axw(`SRB_CTRL_OFF, 32'h4, `SRB_RESP_OKAY);
      run(1'b1, 10'h00A, 8, 1'b1);
   endtask
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      s_reset();
      s_lock();
      s_modes();
      s_lat();
      wrap_up();
   end
endmodule
`default_nettype wire
